// File: lvrf_filter.sv
// Supply monitor digital filter, option register holder and bus slave.
// Assumes comparator and crystal inputs are asynchronous to CORE_CLK and
// that the bus master keeps Avalon-MM waitrequest handshaking.
`timescale 1ns/10ps

module lvrf_filter #(
    parameter lvrf_pkg::lvrf_opt_a_t OPTION_A        = lvrf_pkg::OPT_A_DEFAULT,
    parameter lvrf_pkg::lvrf_opt_b_t OPTION_B        = lvrf_pkg::OPT_B_DEFAULT,
    // Arbitrary value
    parameter logic                  DEVICE_INDICATOR = 1'b0
) (
    // Clock, reset, enable
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    input  wire logic        CLK_EN,
    // Analog comparators and crystal clock, asynchronous
    input  wire logic        SUPPLY_BELOW_FALL,
    input  wire logic        SUPPLY_ABOVE_RISE,
    input  wire logic        CRYSTAL_CLOCK,
    // Core mode indications, same clock
    input  wire logic        WAIT_MODE,
    input  wire logic        STOP_MODE,
    input  wire logic        MONITOR_MODE,
    input  wire logic        SECURITY_OK,
    // Avalon-MM slave
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Monitor results
    output logic             LOW_SUPPLY_FLAG,
    output logic             LV_RESET_REQ,
    output logic             MONITOR_ACTIVE,
    // Option driven controls
    output logic             STOP_ILLEGAL,
    output logic      [12:0] STOP_RECOVERY_CYCLES,
    output logic      [17:0] WATCHDOG_TIMEOUT,
    output logic             WATCHDOG_ENABLE,
    output logic             ROM_BLOCK,
    output logic             EEPROM_DIV_BUS_CLK,
    output logic             EEPROM_ACCESS_DENY
);

    // Option words as seen by software
    localparam lvrf_pkg::lvrf_opt_a_t OPT_A = OPTION_A;
    localparam lvrf_pkg::lvrf_opt_b_t OPT_B = '{
        spare:                       4'h0,
        device_indicator:            DEVICE_INDICATOR,
        eeprom_monitor_protect:      OPTION_B.eeprom_monitor_protect,
        unused_option_bit:           OPTION_B.unused_option_bit,
        eeprom_divider_clock_select: OPTION_B.eeprom_divider_clock_select
    };

    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       xtal_prev_reg;
    logic [3:0] filt_cnt_reg;
    logic [5:0] xtal_cnt_reg;
    logic       flag_reg;
    logic       lv_reset_reg;
    logic       active_reg;
    logic       wait_reg;
    logic [31:0] rdata_reg;
    logic       below_s;
    logic       above_s;
    logic       xtal_edge;
    logic       active_next;
    logic       stop_path;

    // Read decoding, used by the bus slave only
    function automatic logic [31:0] read_word(input logic [3:0] addr,
                                              input logic       flag,
                                              input logic       act);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (addr)
            lvrf_pkg::ADDR_STATUS: begin
                w[lvrf_pkg::STAT_FLAG_BIT]   = flag;
                w[lvrf_pkg::STAT_ACTIVE_BIT] = act;
            end
            lvrf_pkg::ADDR_OPTION_A: w[7:0] = OPT_A;
            lvrf_pkg::ADDR_OPTION_B: w[7:0] = OPT_B;
            default: w = 32'h0000_0000; // Unmapped reads zero
        endcase
        return w;
    endfunction

    // Two-stage synchronisers for comparators and crystal clock
    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge CORE_CLK) begin
                if (RESET) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                end else if (CLK_EN) begin
                    sync1_reg[i] <= (i == 0) ? SUPPLY_BELOW_FALL :
                                    (i == 1) ? SUPPLY_ABOVE_RISE :
                                               CRYSTAL_CLOCK;
                    sync2_reg[i] <= sync1_reg[i];
                end
            end
        end
    endgenerate

    assign below_s   = sync2_reg[0];
    assign above_s   = sync2_reg[1];
    assign xtal_edge = sync2_reg[2] & ~xtal_prev_reg;

    // wait keeps it on; stop without option idles it
    assign active_next = OPT_A.monitor_power_option &
                         ~(STOP_MODE & ~OPT_A.monitor_stop_option);
    // stop path skips the cycle filter
    assign stop_path   = STOP_MODE & OPT_A.monitor_stop_option;

    // Monitor activity
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            active_reg    <= 1'b0;
            xtal_prev_reg <= 1'b0;
        end else if (CLK_EN) begin
            active_reg    <= active_next;
            xtal_prev_reg <= sync2_reg[2];
        end
    end

    // count restarts on early recovery; saturates at nine
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            filt_cnt_reg <= 4'h0;
        end else if (CLK_EN) begin
            if (!active_reg || !below_s) begin
                filt_cnt_reg <= 4'h0;
            end else if (filt_cnt_reg != lvrf_pkg::RESET_FILTER_CYCLES) begin
                filt_cnt_reg <= filt_cnt_reg + 4'h1;
            end
        end
    end

    // Reset request; held until the supply clears the rising trip
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            lv_reset_reg <= 1'b0;
        end else if (CLK_EN) begin
            if (!active_reg || !OPT_A.monitor_reset_option) begin
                lv_reset_reg <= 1'b0;
            end else if (lv_reset_reg) begin
                // one cycle above rising trip releases
                if (above_s) begin
                    lv_reset_reg <= 1'b0;
                end
            end else if (below_s && stop_path) begin
                lv_reset_reg <= 1'b1;
            end else if (filt_cnt_reg == lvrf_pkg::RESET_FILTER_CYCLES) begin
                // nine cycles below then reset, both options set
                lv_reset_reg <= 1'b1;
            end
        end
    end

    // Crystal edge count while below the falling trip
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            xtal_cnt_reg <= 6'h00;
        end else if (CLK_EN) begin
            if (!active_reg || !below_s) begin
                xtal_cnt_reg <= 6'h00;
            end else if (xtal_edge &&
                         xtal_cnt_reg != lvrf_pkg::FLAG_SET_XTAL) begin
                xtal_cnt_reg <= xtal_cnt_reg + 6'h01;
            end
        end
    end

    // Low supply flag; sticky between trips, cleared above rising trip
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            flag_reg <= 1'b0;
        end else if (CLK_EN && active_reg) begin
            if (above_s) begin
                flag_reg <= 1'b0;
            end else if (xtal_cnt_reg == lvrf_pkg::FLAG_SET_XTAL) begin
                // set between 32 and 40 crystal edges
                flag_reg <= 1'b1;
            end
        end
    end

    // Option driven control outputs, registered
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            STOP_ILLEGAL         <= 1'b0;
            STOP_RECOVERY_CYCLES <= lvrf_pkg::STOP_REC_LONG;
            WATCHDOG_TIMEOUT     <= lvrf_pkg::WDOG_SLOW;
            WATCHDOG_ENABLE      <= 1'b0;
            ROM_BLOCK            <= 1'b0;
            EEPROM_DIV_BUS_CLK   <= 1'b0;
            EEPROM_ACCESS_DENY   <= 1'b0;
        end else if (CLK_EN) begin
            STOP_ILLEGAL         <= ~OPT_A.stop_enable;
            STOP_RECOVERY_CYCLES <= OPT_A.short_stop_recovery ?
                                    lvrf_pkg::STOP_REC_SHORT :
                                    lvrf_pkg::STOP_REC_LONG;
            WATCHDOG_TIMEOUT     <= OPT_A.watchdog_rate_select ?
                                    lvrf_pkg::WDOG_FAST :
                                    lvrf_pkg::WDOG_SLOW;
            WATCHDOG_ENABLE      <= ~OPT_A.watchdog_disable;
            ROM_BLOCK            <= OPT_A.rom_protect;
            EEPROM_DIV_BUS_CLK   <= OPT_B.eeprom_divider_clock_select;
            EEPROM_ACCESS_DENY   <= OPT_B.eeprom_monitor_protect &
                                    MONITOR_MODE & ~SECURITY_OK;
        end
    end

    // Bus slave: one wait cycle, then a one-cycle answer
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else if (CLK_EN) begin
            if ((AVS_READ || AVS_WRITE) && wait_reg) begin
                wait_reg <= 1'b0;
                rdata_reg <= AVS_READ ?
                             read_word(AVS_ADDRESS, flag_reg, active_reg) :
                             32'h0000_0000;
            end else begin
                wait_reg <= 1'b1;
            end
        end
    end

    // monitor outputs are flag, reset request and activity only, no interrupt; then the bus outputs
    assign LOW_SUPPLY_FLAG = flag_reg;
    assign LV_RESET_REQ    = lv_reset_reg;
    assign MONITOR_ACTIVE  = active_reg;
    assign AVS_WAITREQUEST = wait_reg;
    assign AVS_READDATA    = rdata_reg;

    // Checks against the monitor behaviour
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    property p_polled_no_reset;
        !OPT_A.monitor_reset_option |-> !lv_reset_reg;
    endproperty
    a_polled_no_reset: assert property (p_polled_no_reset)
        else $error("reset raised with reset option clear");

    property p_reset_needs_both;
        lv_reset_reg |-> OPT_A.monitor_power_option &&
                         OPT_A.monitor_reset_option;
    endproperty
    a_reset_needs_both: assert property (p_reset_needs_both)
        else $error("reset raised without both options");

    property p_filter_nine;
        $rose(lv_reset_reg) && !$past(stop_path) |->
            $past(filt_cnt_reg) == lvrf_pkg::RESET_FILTER_CYCLES;
    endproperty
    a_filter_nine: assert property (p_filter_nine)
        else $error("reset before nine filtered cycles");

    property p_release_one;
        lv_reset_reg && above_s && CLK_EN && active_reg |=> !lv_reset_reg;
    endproperty
    a_release_one: assert property (p_release_one)
        else $error("reset not released after rising trip");

    property p_flag_window;
        $rose(flag_reg) |-> $past(xtal_cnt_reg) > lvrf_pkg::FLAG_MIN_XTAL &&
                            $past(xtal_cnt_reg) < lvrf_pkg::FLAG_MAX_XTAL;
    endproperty
    a_flag_window: assert property (p_flag_window)
        else $error("flag set outside crystal window");

    property p_flag_clear_above;
        above_s && CLK_EN && active_reg |=> !flag_reg;
    endproperty
    a_flag_clear_above: assert property (p_flag_clear_above)
        else $error("flag set above rising trip");

    property p_stop_bypass;
        CLK_EN && active_reg && stop_path && below_s && !lv_reset_reg &&
        OPT_A.monitor_reset_option |=> lv_reset_reg;
    endproperty
    a_stop_bypass: assert property (p_stop_bypass)
        else $error("stop trip did not reset at once");

    property p_stop_idle;
        CLK_EN && STOP_MODE && !OPT_A.monitor_stop_option |=> !active_reg;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("monitor active in stop without option");

    property p_count_restart;
        CLK_EN && !below_s |=> filt_cnt_reg == 4'h0 && xtal_cnt_reg == 6'h00;
    endproperty
    a_count_restart: assert property (p_count_restart)
        else $error("filter count kept after recovery");

    property p_bus_answer;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CLK_EN |=>
            !AVS_WAITREQUEST;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus request not answered next cycle");

    property p_wait_active;
        WAIT_MODE && !STOP_MODE && CLK_EN |=>
            active_reg == OPT_A.monitor_power_option;
    endproperty
    a_wait_active: assert property (p_wait_active)
        else $error("monitor state wrong in wait");

    property p_flag_hold;
        !above_s && xtal_cnt_reg != lvrf_pkg::FLAG_SET_XTAL |=>
            $stable(flag_reg);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag moved between trip levels");

    property p_deny_lock;
        CLK_EN && OPT_B.eeprom_monitor_protect && MONITOR_MODE &&
        !SECURITY_OK |=> EEPROM_ACCESS_DENY;
    endproperty
    a_deny_lock: assert property (p_deny_lock)
        else $error("eeprom open in monitor mode");

    property p_stop_trap;
        CLK_EN |=> STOP_ILLEGAL == !OPT_A.stop_enable;
    endproperty
    a_stop_trap: assert property (p_stop_trap)
        else $error("stop trap differs from option");

    // Main scenarios
    c_filtered_reset: cover property ($rose(lv_reset_reg) && !stop_path);
    c_flag_set:       cover property ($rose(flag_reg));
    c_reset_release:  cover property ($fell(lv_reset_reg));
    c_status_read:    cover property (AVS_READ && !AVS_WAITREQUEST &&
                                      AVS_ADDRESS == lvrf_pkg::ADDR_STATUS);
    c_write_dropped:  cover property (AVS_WRITE && !AVS_WAITREQUEST &&
                                      AVS_WRITEDATA != 32'h0000_0000);

endmodule // lvrf_filter

// File: lvrf_pkg.sv
// Constants, option layouts and register map of the supply monitor filter.
// Assumes one 100 MHz core clock and a byte-addressed Avalon-MM slave.
package lvrf_pkg;

    // Core clock rate in MHz
    localparam int unsigned CORE_CLK_MHZ = 100;

    // Register byte addresses (word aligned)
    localparam logic [3:0] ADDR_STATUS   = 4'h0;
    localparam logic [3:0] ADDR_OPTION_A = 4'h4;
    localparam logic [3:0] ADDR_OPTION_B = 4'h8;

    // Status field position
    localparam int unsigned STAT_FLAG_BIT   = 0;
    localparam int unsigned STAT_ACTIVE_BIT = 1;

    // Filter lengths
    localparam logic [3:0] RESET_FILTER_CYCLES = 4'h9;  // CPU cycles
    localparam logic [5:0] FLAG_MIN_XTAL       = 6'h20; // 32 crystal edges
    localparam logic [5:0] FLAG_MAX_XTAL       = 6'h28; // 40 crystal edges
    localparam logic [5:0] FLAG_SET_XTAL       = 6'h24; // Midway, 36

    // Stop exit delays and watchdog timeouts, crystal cycles
    localparam logic [12:0] STOP_REC_SHORT = 13'h0020;  // 32
    localparam logic [12:0] STOP_REC_LONG  = 13'h1000;  // 4096
    localparam logic [17:0] WDOG_FAST      = 18'h01ff0; // 8176
    localparam logic [17:0] WDOG_SLOW      = 18'h3fff0; // 262128

    // First option register, hardwired at manufacture
    typedef struct packed {
        logic monitor_stop_option;
        logic rom_protect;
        logic monitor_reset_option;
        logic monitor_power_option;
        logic short_stop_recovery;
        logic watchdog_rate_select;
        logic stop_enable;
        logic watchdog_disable;
    } lvrf_opt_a_t;

    // Second option register, upper bits read as zero
    typedef struct packed {
        logic [3:0] spare;
        logic       device_indicator;
        logic       eeprom_monitor_protect;
        logic       unused_option_bit;
        logic       eeprom_divider_clock_select;
    } lvrf_opt_b_t;

    // Default option values
    localparam lvrf_opt_a_t OPT_A_DEFAULT = 8'h30;
    localparam lvrf_opt_b_t OPT_B_DEFAULT = 8'h00;

endpackage

// File: tb_top.sv
// Bench of the supply monitor filter with a reset and a polled instance.
// Assumes lvrf_pkg and lvrf_filter compiled first; one 100 MHz clock.
`timescale 1ns/10ps

module tb_top;
    // Reset instance and polled instance options
    localparam lvrf_pkg::lvrf_opt_a_t OA_R = 8'hb2;
    localparam lvrf_pkg::lvrf_opt_b_t OB_R = 8'h05;
    localparam lvrf_pkg::lvrf_opt_a_t OA_P = 8'h5d;
    localparam lvrf_pkg::lvrf_opt_b_t OB_P = 8'h0a;
    // Device indicator, arbitrary value
    localparam logic DEV_IND = 1'b0;

    logic        clk = 1'b0;
    logic        rst, clk_en, below, above, xtal;
    logic        wait_m, stop_m, mon_m, sec_ok, rd, wr;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, rdata_p, seed;
    logic        waitreq, flag, rreq, act, s_ill, wd_en, rom_b, div_b, deny;
    logic        waitreq_p, flag_p, rreq_p, act_p, s_ill_p, wd_en_p;
    logic        rom_p, div_p, deny_p;
    logic        poll_rst_seen = 1'b0;
    logic [12:0] rec, rec_p;
    logic [17:0] wdt, wdt_p;
    int          errors, n_checks;

    lvrf_filter #(.OPTION_A(OA_R), .OPTION_B(OB_R),
        .DEVICE_INDICATOR(DEV_IND)) lvrf_filter_i (
        .CORE_CLK(clk), .RESET(rst), .CLK_EN(clk_en),
        .SUPPLY_BELOW_FALL(below), .SUPPLY_ABOVE_RISE(above),
        .CRYSTAL_CLOCK(xtal), .WAIT_MODE(wait_m), .STOP_MODE(stop_m),
        .MONITOR_MODE(mon_m), .SECURITY_OK(sec_ok), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .LOW_SUPPLY_FLAG(flag), .LV_RESET_REQ(rreq), .MONITOR_ACTIVE(act),
        .STOP_ILLEGAL(s_ill), .STOP_RECOVERY_CYCLES(rec),
        .WATCHDOG_TIMEOUT(wdt), .WATCHDOG_ENABLE(wd_en), .ROM_BLOCK(rom_b),
        .EEPROM_DIV_BUS_CLK(div_b), .EEPROM_ACCESS_DENY(deny));

    lvrf_filter #(.OPTION_A(OA_P), .OPTION_B(OB_P),
        .DEVICE_INDICATOR(DEV_IND)) lvrf_filter_poll_i (
        .CORE_CLK(clk), .RESET(rst), .CLK_EN(clk_en),
        .SUPPLY_BELOW_FALL(below), .SUPPLY_ABOVE_RISE(above),
        .CRYSTAL_CLOCK(xtal), .WAIT_MODE(wait_m), .STOP_MODE(stop_m),
        .MONITOR_MODE(mon_m), .SECURITY_OK(sec_ok), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_READDATA(rdata_p), .AVS_WAITREQUEST(waitreq_p),
        .LOW_SUPPLY_FLAG(flag_p), .LV_RESET_REQ(rreq_p),
        .MONITOR_ACTIVE(act_p), .STOP_ILLEGAL(s_ill_p),
        .STOP_RECOVERY_CYCLES(rec_p), .WATCHDOG_TIMEOUT(wdt_p),
        .WATCHDOG_ENABLE(wd_en_p), .ROM_BLOCK(rom_p),
        .EEPROM_DIV_BUS_CLK(div_p), .EEPROM_ACCESS_DENY(deny_p));

    // Free running core clock
    always #5 clk = ~clk;

    // Sticky record: polled instance must never ask for reset
    always @(posedge clk) begin
        if (rreq_p === 1'b1) poll_rst_seen <= 1'b1;
    end

    // Xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Register image from options; upper bits always zero
    function automatic logic [31:0] exp_rd(input logic [3:0] a,
            input logic [7:0] oa, input logic [7:0] ob, input logic ac);
        case (a)
            lvrf_pkg::ADDR_STATUS:   return {30'h0, ac, 1'b0};
            lvrf_pkg::ADDR_OPTION_A: return {24'h0, oa};
            lvrf_pkg::ADDR_OPTION_B: return {28'h0, DEV_IND, ob[2:0]};
            default:                 return 32'h0;
        endcase
    endfunction

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t bit got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Avalon transfer; held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       output logic [31:0] d, output logic [31:0] dp);
        int t;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= seed;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (waitreq !== 1'b0 && t < 50);
        d = rdata;
        dp = rdata_p;
        chk_bit(t < 50, 1'b1);
        chk_bit(waitreq_p, 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // One cycle above the rising trip, then settle
    task automatic rise_pulse();
        above <= 1'b1;
        cyc(1);
        above <= 1'b0;
        cyc(6);
    endtask

    // Supply low over n crystal periods of 8 core cycles
    task automatic grow_flag(input int n);
        below <= 1'b1;
        for (int k = 1; k <= n; k++) begin
            cyc(4);
            xtal <= 1'b1;
            cyc(4);
            xtal <= 1'b0;
            if (k <= 31) chk_bit(flag_p, 1'b0);
        end
        below <= 1'b0;
    endtask

    // Hang guard, far beyond the fewer than a thousand cycles needed
    initial begin
        #100000;
        errors++;
        close_out();
    end

    // Main sequence
    initial begin
        logic [31:0] d, dp;
        logic [3:0]  a;
        int          n;
        rst = 1; clk_en = 1; below = 0; above = 0; xtal = 0;
        wait_m = 0; stop_m = 0; mon_m = 0; sec_ok = 0;
        rd = 0; wr = 0; addr = 0; wdata = 0;
        errors = 0; n_checks = 0; seed = 32'h257a4f89;
        cyc(8);
        chk_bit(flag, 1'b0);
        chk_bit(waitreq, 1'b1);
        rst <= 1'b0;
        cyc(3);
        // Hardwired option controls of both instances
        chk_bit(s_ill, 1'b0);
        chk_bit(s_ill_p, 1'b1);
        chk_word({19'h0, rec}, 32'd4096);
        chk_word({19'h0, rec_p}, 32'd32);
        chk_word({14'h0, wdt}, 32'd262128);
        chk_word({14'h0, wdt_p}, 32'd8176);
        chk_bit(wd_en, 1'b1);
        chk_bit(wd_en_p, 1'b0);
        chk_bit(rom_b, 1'b0);
        chk_bit(rom_p, 1'b1);
        chk_bit(div_b, 1'b1);
        chk_bit(div_p, 1'b0);
        mon_m <= 1'b1;
        cyc(2);
        chk_bit(deny, 1'b1);
        chk_bit(deny_p, 1'b0);
        sec_ok <= 1'b1;
        cyc(2);
        chk_bit(deny, 1'b0);
        // Writes everywhere must change nothing, then random reads
        for (int i = 0; i < 4; i++) bus(1'b1, 4'(4 * i), d, dp);
        for (int i = 0; i < 14; i++) begin
            seed = xs(seed);
            a = (i < 4) ? 4'(4 * i) : {seed[1:0], 2'b00};
            bus(1'b0, a, d, dp);
            chk_word(d, exp_rd(a, OA_R, OB_R, 1'b1));
            chk_word(dp, exp_rd(a, OA_P, OB_P, 1'b1));
        end
        // Short dips of 1 to 8 cycles in wait must never reset
        wait_m <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            below <= 1'b1;
            cyc(1 + int'(seed[2:0]));
            below <= 1'b0;
            cyc(1);
        end
        cyc(4);
        chk_bit(rreq, 1'b0);
        // Held low with random stalls; count enabled cycles
        below <= 1'b1;
        n = 0;
        for (int i = 0; i < 80 && rreq !== 1'b1; i++) begin
            @(posedge clk);
            if (clk_en === 1'b1) n++;
            seed = xs(seed);
            clk_en <= seed[0] | seed[1];
        end
        // Two sync edges, nine filter edges, one to register, one to see
        chk_bit((n >= 12) && (n <= 13), 1'b1);
        @(posedge clk);
        clk_en <= 1'b1;
        below <= 1'b0;
        chk_bit(act, 1'b1);
        cyc(6);
        chk_bit(rreq, 1'b1);
        rise_pulse();
        chk_bit(rreq, 1'b0);
        wait_m <= 1'b0;
        // Stop: short trip bypasses the filter only with stop option
        stop_m <= 1'b1;
        cyc(3);
        chk_bit(act, 1'b1);
        chk_bit(act_p, 1'b0);
        below <= 1'b1;
        cyc(2);
        below <= 1'b0;
        cyc(4);
        chk_bit(rreq, 1'b1);
        rise_pulse();
        stop_m <= 1'b0;
        cyc(3);
        // Flag filter on the crystal clock, hold and clear
        grow_flag(42);
        cyc(4);
        chk_bit(flag_p, 1'b1);
        chk_bit(flag, 1'b1);
        cyc(20);
        chk_bit(flag_p, 1'b1);
        rise_pulse();
        chk_bit(flag_p, 1'b0);
        grow_flag(42);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        chk_bit(flag_p, 1'b0);
        chk_bit(flag, 1'b0);
        chk_bit(poll_rst_seen, 1'b0);
        cyc(3);
        close_out();
    end
endmodule // tb_top
